// ### rtl/dpm_cnt.sv
`timescale 1ns/1ps
// phase timer: loads a count, pulses o_done when it runs out
module dpm_cnt (
    // clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_nrst,
    // control
    input  wire logic       i_load,
    input  wire logic [3:0] i_count,
    // status
    output logic            o_done
);
    logic [3:0] cnt_q;
    logic       run_q;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_q <= 4'h0;
            run_q <= 1'b0;
        end else if (i_load) begin
            cnt_q <= i_count - 4'h1;
            run_q <= 1'b1;
        end else if (run_q) begin
            if (cnt_q == 4'h0) begin
                run_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end

    // done must not look at the load: the host loads from done, which would close a loop
    assign o_done = run_q && (cnt_q == 4'h0);
endmodule

// ### rtl/dpm_host.sv
`timescale 1ns/1ps
// How it works
// - writes end on rising read/write edge, selects still low
// - reads assert select and drive, wait access
// - writes wait for busy to settle
// - eight token latches, never both selects
// - recovery gap before token read-back
module dpm_host
    import dpm_pkg::*;
(
    // clock and reset
    input  wire logic              i_core_clk,
    input  wire logic              i_nrst,
    // request side
    input  wire logic              i_req_valid,
    input  wire dpm_pkg::dpm_req_t i_req,
    output logic                   o_req_ready,
    output logic                   o_rsp_valid,
    output logic [7:0]             o_rsp_data,
    output logic                   o_rsp_busy,
    output logic                   o_mbox_irq,
    // device pins of this port
    output dpm_pkg::dpm_pins_t     o_pins,
    output logic [7:0]             o_data_out,
    output logic                   o_data_oe,
    input  wire logic [7:0]        i_data_in,
    input  wire logic              i_busy_n,
    input  wire logic              i_mbox_flag_n
);
    import dpm_pkg::*;

    typedef enum logic [2:0] {
        DPM_IDLE   = 3'h0,
        DPM_SETUP  = 3'h1,
        DPM_PULSE  = 3'h2,
        DPM_ACCESS = 3'h3,
        DPM_RECOV  = 3'h4
    } dpm_state_t;

    dpm_state_t state_q;
    dpm_req_t   req_q;
    dpm_pins_t  pins_q;
    logic [7:0] wdata_q;
    logic       data_oe_q;
    logic [7:0] rsp_data_q;
    logic       rsp_valid_q;
    logic       rsp_busy_q;
    logic       tok_recov_q;
    logic       tmr_load;
    logic [3:0] tmr_count;
    logic       tmr_done;

    function automatic logic is_write(input dpm_cmd_t c);
        return (c == DPM_CMD_WRITE) || (c == DPM_CMD_TOK_WRITE);
    endfunction

    function automatic logic is_token(input dpm_cmd_t c);
        return (c == DPM_CMD_TOK_READ) || (c == DPM_CMD_TOK_WRITE);
    endfunction

    dpm_cnt u_tmr (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_load     (tmr_load),
        .i_count    (tmr_count),
        .o_done     (tmr_done)
    );

    assign o_req_ready = (state_q == DPM_IDLE);

    // timer loads on each phase entry
    always_comb begin
        tmr_load  = 1'b0;
        tmr_count = ACCESS_CYC;
        case (state_q)
            DPM_IDLE: begin
                if (i_req_valid) begin
                    tmr_load  = 1'b1;
                    // after token write, recovery gap first
                    tmr_count = (tok_recov_q && is_token(i_req.cmd)) ? RECOVERY_CYC : 4'h1;
                end
            end
            DPM_SETUP: begin
                if (tmr_done) begin
                    tmr_load  = 1'b1;
                    // writes wait for busy to settle in the pulse phase, read/write already low
                    tmr_count = is_write(req_q.cmd) ? BUSY_CYC : ACCESS_CYC;
                end
            end
            DPM_PULSE: begin
                if (tmr_done) begin
                    tmr_load  = 1'b1;
                    tmr_count = WPULSE_CYC;
                end
            end
            DPM_ACCESS: begin
                if (tmr_done) begin
                    tmr_load  = 1'b1;
                    tmr_count = RECOVERY_CYC;
                end
            end
            DPM_RECOV: begin
                tmr_load = 1'b0;
            end
            default: begin
                tmr_load = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= DPM_IDLE;
            req_q   <= '0;
        end else begin
            case (state_q)
                DPM_IDLE: begin
                    if (i_req_valid) begin
                        req_q   <= i_req;
                        state_q <= DPM_SETUP;
                    end
                end
                DPM_SETUP: begin
                    if (tmr_done) begin
                        state_q <= is_write(req_q.cmd) ? DPM_PULSE : DPM_ACCESS;
                    end
                end
                DPM_PULSE: begin
                    if (tmr_done) begin
                        state_q <= DPM_ACCESS;
                    end
                end
                DPM_ACCESS: begin
                    if (tmr_done) begin
                        state_q <= DPM_RECOV;
                    end
                end
                DPM_RECOV: begin
                    if (tmr_done) begin
                        state_q <= DPM_IDLE;
                    end
                end
                default: begin
                    state_q <= DPM_IDLE;
                end
            endcase
        end
    end

    // device pin drive
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pins_q    <= '{sel_n: 1'b1, tok_sel_n: 1'b1, rw: 1'b1, oe_n: 1'b1, addr: '0};
            wdata_q   <= 8'h00;
            data_oe_q <= 1'b0;
        end else begin
            case (state_q)
                DPM_IDLE: begin
                    pins_q    <= '{sel_n: 1'b1, tok_sel_n: 1'b1, rw: 1'b1, oe_n: 1'b1, addr: pins_q.addr};
                    data_oe_q <= 1'b0;
                    if (i_req_valid) begin
                        pins_q.addr <= is_token(i_req.cmd)
                            ? {14'h0000, i_req.addr[TOKEN_ADDR_W-1:0]} : i_req.addr;
                        // token write carries bit zero only
                        wdata_q <= (i_req.cmd == DPM_CMD_TOK_WRITE)
                            ? {7'h00, i_req.wdata[TOKEN_BIT]} : i_req.wdata;
                    end
                end
                DPM_SETUP: begin
                    // never both selects low together
                    pins_q.sel_n     <= is_token(req_q.cmd);
                    pins_q.tok_sel_n <= !is_token(req_q.cmd);
                    pins_q.rw        <= !is_write(req_q.cmd);
                    pins_q.oe_n      <= is_write(req_q.cmd);
                    data_oe_q        <= is_write(req_q.cmd);
                end
                DPM_ACCESS: begin
                    if (is_write(req_q.cmd)) begin
                        // rising read/write edge ends the write, data still held
                        pins_q.rw <= 1'b1;
                    end
                end
                DPM_RECOV: begin
                    pins_q.sel_n     <= 1'b1;
                    pins_q.tok_sel_n <= 1'b1;
                    pins_q.oe_n      <= 1'b1;
                    pins_q.rw        <= 1'b1;
                    data_oe_q        <= 1'b0;
                end
                default: begin
                    data_oe_q <= data_oe_q;
                end
            endcase
        end
    end

    // response capture, after access delay has elapsed
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rsp_valid_q <= 1'b0;
            rsp_data_q  <= 8'h00;
            rsp_busy_q  <= 1'b0;
        end else begin
            rsp_valid_q <= 1'b0;
            if (state_q == DPM_ACCESS && tmr_done) begin
                rsp_valid_q <= 1'b1;
                rsp_data_q  <= is_write(req_q.cmd) ? 8'h00 : i_data_in;
                rsp_busy_q  <= !i_busy_n;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tok_recov_q <= 1'b0;
        end else if (state_q == DPM_RECOV && tmr_done) begin
            tok_recov_q <= (req_q.cmd == DPM_CMD_TOK_WRITE);
        end else if (state_q == DPM_SETUP) begin
            tok_recov_q <= 1'b0;
        end
    end

    assign o_pins      = pins_q;
    assign o_data_out  = wdata_q;
    assign o_data_oe   = data_oe_q;
    assign o_rsp_valid = rsp_valid_q;
    assign o_rsp_data  = rsp_data_q;
    assign o_rsp_busy  = rsp_busy_q;
    // flag from device is active low
    assign o_mbox_irq  = !i_mbox_flag_n;

    a_never_both_sel: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        !(!o_pins.sel_n && !o_pins.tok_sel_n)) else $error("both selects low");
    a_idle_float: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (state_q == DPM_IDLE) |=> !o_data_oe) else $error("data driven while idle");
    a_write_no_oe: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (o_data_oe && !o_pins.rw) |-> o_pins.oe_n) else $error("output enable during write");
    a_write_end_data: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        ($rose(o_pins.rw) && $past(o_data_oe)) |-> o_data_oe && $stable(o_data_out))
        else $error("data dropped at write end");
    a_read_access: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (o_rsp_valid && !$past(is_write(req_q.cmd))) |-> $past(!o_pins.oe_n, 1))
        else $error("read sampled without drive");
    a_token_addr: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        !o_pins.tok_sel_n |-> (o_pins.addr[16:3] == 14'h0000)) else $error("token address high bits set");
    a_token_data: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (!o_pins.tok_sel_n && o_data_oe) |-> (o_data_out[7:1] == 7'h00)) else $error("token data wide");
    a_recov_gap: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        $rose(o_pins.tok_sel_n) |=> o_pins.tok_sel_n) else $error("token reselected too soon");
    a_irq_level: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        o_mbox_irq == !i_mbox_flag_n) else $error("irq not following flag");

    c_read:   cover property (@(posedge i_core_clk) o_rsp_valid && req_q.cmd == DPM_CMD_READ);
    c_write:  cover property (@(posedge i_core_clk) o_rsp_valid && req_q.cmd == DPM_CMD_WRITE);
    c_tok_rd: cover property (@(posedge i_core_clk) o_rsp_valid && req_q.cmd == DPM_CMD_TOK_READ);
    c_busy:   cover property (@(posedge i_core_clk) o_rsp_valid && o_rsp_busy);
endmodule

// ### rtl/dpm_pkg.sv
package dpm_pkg;

    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;

    // mailbox locations of the two ports
    localparam logic [16:0] MBOX_RIGHT_ADDR = 17'h1FFFF;
    localparam logic [16:0] MBOX_LEFT_ADDR  = 17'h1FFFE;

    // token latches: address bits 0..2 select, data bit 0 carries value
    localparam int TOKEN_ADDR_W = 3;
    localparam int TOKEN_BIT    = 0;

    // timing figures in ns, clock period 50 ns
    localparam int CLK_PERIOD_NS           = 50;
    localparam int SELECT_ACCESS_NS        = 25;
    localparam int DRIVE_ACCESS_NS         = 15;
    localparam int BUSY_SETTLE_NS          = 25;
    localparam int TOKEN_RECOVERY_NS       = 10;
    localparam int WRITE_PULSE_NS          = 25;

    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int ACCESS_NS    = (SELECT_ACCESS_NS > DRIVE_ACCESS_NS) ? SELECT_ACCESS_NS : DRIVE_ACCESS_NS;
    localparam logic [3:0] ACCESS_CYC   = 4'(ns_to_cyc(ACCESS_NS));
    localparam logic [3:0] BUSY_CYC     = 4'(ns_to_cyc(BUSY_SETTLE_NS));
    localparam logic [3:0] RECOVERY_CYC = 4'(ns_to_cyc(TOKEN_RECOVERY_NS));
    localparam logic [3:0] WPULSE_CYC   = 4'(ns_to_cyc(WRITE_PULSE_NS));

    typedef enum logic [1:0] {
        DPM_CMD_READ     = 2'h0,
        DPM_CMD_WRITE    = 2'h1,
        DPM_CMD_TOK_READ = 2'h2,
        DPM_CMD_TOK_WRITE= 2'h3
    } dpm_cmd_t;

    typedef struct packed {
        dpm_cmd_t          cmd;
        logic [16:0]       addr;
        logic [7:0]        wdata;
    } dpm_req_t;

    typedef struct packed {
        logic        sel_n;
        logic        tok_sel_n;
        logic        rw;
        logic        oe_n;
        logic [16:0] addr;
    } dpm_pins_t;

endpackage

// ### verif/dpm_dev_model.sv
`timescale 1ns/1ps
// one device port as the host sees it; the peer port is worked by the bench
module dpm_dev_model
    import dpm_pkg::*;
(
    // host side
    input  wire logic               i_core_clk,
    input  wire dpm_pkg::dpm_pins_t i_pins,
    input  wire logic [7:0]         i_data,
    input  wire logic               i_data_oe,
    output logic [7:0]              o_data,
    output logic                    o_busy_n,
    output logic                    o_flag_n,
    // peer side
    input  wire logic               i_busy,
    input  wire logic [1:0]         i_peer_op,
    input  wire logic [2:0]         i_peer_idx,
    input  wire logic               i_peer_val,
    output logic                    o_peer_flag_n
);
    logic [7:0]  mem [logic [16:0]];
    logic [1:0]  own [8];
    logic        pend [8];
    logic        wr_q, twr_q, trd_q;
    logic [16:0] wa_q;
    logic [7:0]  wd_q;
    // busy comes in from the bench as from a master; it settles before the access ends
    assign o_busy_n = ~i_busy;
    // side 1 host, 2 peer; a pending request belongs to the non-owner
    // both sides are serialised through this task, so exactly one wins a race
    task automatic tok_wr(input logic [1:0] s, input logic [2:0] i, input logic v);
        if (!v) begin
            if (own[i] == 2'h0) own[i] = s;
            else if (own[i] != s) pend[i] = 1'b1;
        end else begin
            if (own[i] == s) own[i] = pend[i] ? 2'h3 - s : 2'h0;
            pend[i] = 1'b0;
        end
    endtask
    initial begin
        for (int k = 0; k < 8; k++) begin
            own[k] = 2'h0;
            pend[k] = 1'b0;
        end
        {wr_q, twr_q, trd_q} = 3'h0;
        {o_flag_n, o_peer_flag_n} = 2'h3;
        o_data = 8'hA5;
    end
    always @(negedge i_core_clk) begin
        if ((!i_pins.sel_n || !i_pins.tok_sel_n) && !i_pins.rw && i_data_oe) begin
            wr_q = 1'b1;
            twr_q = !i_pins.tok_sel_n;
            wa_q = i_pins.addr;
            wd_q = i_data;
        end else if (wr_q) begin
            // committed only when the write strobe ends
            wr_q = 1'b0;
            if (twr_q) tok_wr(2'h1, wa_q[2:0], wd_q[0]);
            else if (!i_busy) begin
                mem[wa_q] = wd_q;
                if (wa_q == MBOX_RIGHT_ADDR) o_peer_flag_n = 1'b0;
            end
        end
        if (!i_pins.sel_n && !i_pins.oe_n && i_pins.rw) begin
            o_data = mem.exists(i_pins.addr) ? mem[i_pins.addr] : 8'h00;
            if (i_pins.addr == MBOX_LEFT_ADDR && !i_busy) o_flag_n = 1'b1;
        end else if (!i_pins.tok_sel_n && i_pins.sel_n && !i_pins.oe_n && i_pins.rw) begin
            if (!trd_q) o_data = {8{own[i_pins.addr[2:0]] != 2'h1}};
        end else o_data = ~o_data;
        trd_q = !i_pins.tok_sel_n && !i_pins.oe_n;
    end
    always @(posedge i_core_clk) begin
        if (i_peer_op == 2'h1) begin
            mem[MBOX_LEFT_ADDR] = {5'h00, i_peer_idx};
            o_flag_n = 1'b0;
        end
        if (i_peer_op == 2'h2) o_peer_flag_n = 1'b1;
        if (i_peer_op == 2'h3) tok_wr(2'h2, i_peer_idx, i_peer_val);
    end
endmodule

// ### verif/dpm_host_tb_top.sv
`timescale 1ns/1ps
module dpm_host_tb_top;
    import dpm_pkg::*;
    logic        clk, nrst, req_valid, req_ready, rsp_valid, rsp_busy, irq, data_oe;
    logic        busy_n, flag_n, peer_flag_n, busy, peer_val;
    logic [7:0]  rsp_data, dout, din;
    logic [1:0]  peer_op;
    logic [2:0]  peer_idx;
    dpm_req_t    req;
    dpm_pins_t   pins;
    logic [8:0]  expq [$];
    logic [16:0] ad [4];
    logic [7:0]  dd [4];
    int          n_fail, checks_done, seed;

    dpm_host u_dpm_host (.i_core_clk(clk), .i_nrst(nrst), .i_req_valid(req_valid), .i_req(req),
        .o_req_ready(req_ready), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data), .o_rsp_busy(rsp_busy),
        .o_mbox_irq(irq), .o_pins(pins), .o_data_out(dout), .o_data_oe(data_oe), .i_data_in(din),
        .i_busy_n(busy_n), .i_mbox_flag_n(flag_n));
    dpm_dev_model u_dpm_dev_model (.i_core_clk(clk), .i_pins(pins), .i_data(dout), .i_data_oe(data_oe),
        .o_data(din), .o_busy_n(busy_n), .o_flag_n(flag_n), .i_busy(busy), .i_peer_op(peer_op),
        .i_peer_idx(peer_idx), .i_peer_val(peer_val), .o_peer_flag_n(peer_flag_n));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic req_do(input dpm_cmd_t c, input logic [16:0] a, input logic [7:0] w, input logic [8:0] e);
        int k;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{cmd: c, addr: a, wdata: w};
        expq.push_back(e);
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (req_ready !== 1'b1 && k < 50);
        if (k == 50) begin
            chk(16'h0, 16'h1);
            tally_and_finish();
        end
        @(posedge clk);
        req_valid <= 1'b0;
    endtask
    task automatic wait_idle;
        int k;
        for (k = 0; k < 50 && (expq.size() > 0 || req_ready !== 1'b1); k++) @(negedge clk);
        if (k == 50) begin
            chk(16'h0, 16'h1);
            tally_and_finish();
        end
        repeat (2) @(negedge clk);
    endtask
    task automatic peer(input logic [1:0] op, input logic [2:0] i, input logic v);
        @(posedge clk);
        peer_op <= op;
        peer_idx <= i;
        peer_val <= v;
        @(posedge clk);
        peer_op <= 2'h0;
        @(negedge clk);
    endtask

    // oldest expectation meets each answer
    always @(negedge clk) begin
        if (rsp_valid === 1'b1) begin
            if (expq.size() == 0) chk(16'h1FF, 16'h0);
            else chk({rsp_busy, rsp_data}, expq.pop_front());
        end
    end

    initial begin
        seed = 32'hd5eb;
        n_fail = 0;
        checks_done = 0;
        {nrst, req_valid, busy, peer_val} = 4'h0;
        req = '0;
        peer_op = 2'h0;
        peer_idx = 3'h0;
        repeat (3) @(posedge clk);
        chk({pins.sel_n, pins.tok_sel_n, pins.rw, pins.oe_n, data_oe, rsp_valid, req_ready}, 16'h79);
        nrst <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            ad[i] = (17'($random(seed)) & 17'h0FFF8) | 17'(i);
            dd[i] = 8'($random(seed));
            req_do(DPM_CMD_WRITE, ad[i], dd[i], 9'h000);
        end
        for (int i = 0; i < 4; i++) req_do(DPM_CMD_READ, ad[i], 8'h00, {1'b0, dd[i]});
        wait_idle();
        peer(2'h1, 3'h5, 1'b0);
        chk(irq, 16'h1);
        req_do(DPM_CMD_READ, MBOX_LEFT_ADDR, 8'h00, 9'h005);
        wait_idle();
        chk(irq, 16'h0);
        req_do(DPM_CMD_WRITE, MBOX_RIGHT_ADDR, 8'h3C, 9'h000);
        req_do(DPM_CMD_READ, MBOX_RIGHT_ADDR, 8'h00, 9'h03C);
        wait_idle();
        chk(peer_flag_n, 16'h0);
        peer(2'h2, 3'h0, 1'b0);
        @(posedge clk);
        busy <= 1'b1;
        peer(2'h1, 3'h6, 1'b0);
        req_do(DPM_CMD_READ, MBOX_LEFT_ADDR, 8'h00, 9'h106);
        req_do(DPM_CMD_WRITE, MBOX_RIGHT_ADDR, 8'h77, 9'h100);
        wait_idle();
        chk({irq, peer_flag_n}, 16'h3);
        @(posedge clk);
        busy <= 1'b0;
        req_do(DPM_CMD_READ, MBOX_LEFT_ADDR, 8'h00, 9'h006);
        req_do(DPM_CMD_READ, MBOX_RIGHT_ADDR, 8'h00, 9'h03C);
        wait_idle();
        chk(irq, 16'h0);
        for (int i = 0; i < 8; i++) begin
            req_do(DPM_CMD_TOK_WRITE, {14'h3A5B, 3'(i)}, 8'hFE, 9'h000);
            req_do(DPM_CMD_TOK_READ, 17'(i), 8'h00, 9'h000);
            req_do(DPM_CMD_TOK_WRITE, 17'(i), 8'h01, 9'h000);
            req_do(DPM_CMD_TOK_READ, 17'(i), 8'h00, 9'h0FF);
        end
        req_do(DPM_CMD_TOK_WRITE, 17'h3, 8'h00, 9'h000);
        wait_idle();
        peer(2'h3, 3'h3, 1'b0);
        req_do(DPM_CMD_TOK_READ, 17'h3, 8'h00, 9'h000);
        req_do(DPM_CMD_TOK_WRITE, 17'h3, 8'hFF, 9'h000);
        req_do(DPM_CMD_TOK_READ, 17'h3, 8'h00, 9'h0FF);
        req_do(DPM_CMD_TOK_WRITE, 17'h3, 8'h00, 9'h000);
        wait_idle();
        peer(2'h3, 3'h3, 1'b1);
        req_do(DPM_CMD_TOK_READ, 17'h3, 8'h00, 9'h000);
        req_do(DPM_CMD_TOK_WRITE, 17'h3, 8'h01, 9'h000);
        req_do(DPM_CMD_TOK_READ, 17'h3, 8'h00, 9'h0FF);
        wait_idle();
        tally_and_finish();
    end
endmodule
